/* File: dv/tb.sv */
// Purpose: directed bench for tio_port
// Assumes: 200 MHz clock, inputs moved on rising edges
// Notes:   pin tasks of the apparatus model settle the sync path
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 0, i_resetn = 0, i_usb_link = 0, i_rd = 0, i_wr = 0;
   logic [7:0] i_wdata = 8'h00, i_in_line, o_rdata, o_out_line, seen;
   logic i_latch_n, o_rvalid, o_latched, o_avail;
   int num_errors = 0, tests_run = 0, cyc = 0;
   tio_port tio_port_inst (.i_clk, .i_resetn, .i_in_line, .i_latch_n,
      .i_usb_link, .i_rd, .i_wr, .i_wdata, .o_rdata, .o_rvalid,
      .o_out_line, .o_latched, .o_avail);
   tio_apparatus tio_apparatus_inst (.i_clk, .i_out_line(o_out_line),
      .o_in_line(i_in_line), .o_latch_n(i_latch_n), .o_seen(seen));
   initial forever #2.5 i_clk = ~i_clk;
   task automatic chk(input string n, input logic [7:0] e, g);
      tests_run++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", n, e, g);
         num_errors++;
      end
   endtask
   task automatic results;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         results;
      end
   end
   task automatic rd(input string n, input logic [7:0] e);
      @(posedge i_clk) i_rd <= 1'b1;
      @(posedge i_clk) i_rd <= 1'b0;
      // answer stands one cycle only: look right after the taking edge
      #1;
      chk("rvalid", 8'h01, {7'h00, o_rvalid});
      chk(n, e, o_rdata);
      @(posedge i_clk) #1;
      chk("rvalid low", 8'h00, {7'h00, o_rvalid});
   endtask
   task automatic wr(input logic [7:0] v, e);
      @(posedge i_clk) begin
         i_wr <= 1'b1;
         i_wdata <= v;
      end
      @(posedge i_clk) i_wr <= 1'b0;
      @(posedge i_clk) #1;
      chk("out_line", e, o_out_line);
   endtask
   task automatic t_out;
      #1 chk("reset out", 8'h00, o_out_line);
      wr(8'h81, 8'h81);
      wr(8'h7e, 8'h7e);
      repeat (5) @(posedge i_clk);
      #1 chk("held", 8'h7e, o_out_line);
      chk("seen", 8'h7e, seen);
      chk("avail", 8'h01, {7'h00, o_avail});
   endtask
   task automatic t_pins;
      tio_apparatus_inst.put(8'hff, 8'h03);
      rd("live 03", 8'h03);
      tio_apparatus_inst.put(8'h00, 8'h00);
      rd("open ff", 8'hff);
      tio_apparatus_inst.put(8'hff, 8'h03);
      tio_apparatus_inst.hold(1'b0);
      chk("latched", 8'h01, {7'h00, o_latched});
      tio_apparatus_inst.put(8'hff, 8'h5a);
      rd("held 03", 8'h03);
      tio_apparatus_inst.hold(1'b1);
      rd("live 5a", 8'h5a);
   endtask
   task automatic t_usb;
      @(posedge i_clk) i_usb_link <= 1'b1;
      wr(8'h33, 8'h7e);
      rd("usb rd", 8'h00);
      chk("usb avail", 8'h00, {7'h00, o_avail});
   endtask
   initial begin
      repeat (3) @(posedge i_clk);
      i_resetn <= 1'b1;
      t_out;
      t_pins;
      t_usb;
      results;
   end
endmodule
`default_nettype wire

/* File: dv/tio_apparatus.sv */
// Purpose: user apparatus on the ttl pins
// Assumes: undriven inputs float to the outside pull-up
// Notes:   tasks wait out the pin synchroniser before returning
`default_nettype none
module tio_apparatus (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_out_line,
   output var  logic [7:0] o_in_line = 8'hff,
   output var  logic       o_latch_n = 1'b1,
   output var  logic [7:0] o_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   task automatic put(input logic [7:0] drv, input logic [7:0] lvl);
      @(posedge i_clk) o_in_line <= ~drv | lvl;
      repeat (3) @(posedge i_clk);
      #1;
   endtask
   task automatic hold(input logic l);
      @(posedge i_clk) o_latch_n <= l;
      repeat (3) @(posedge i_clk);
      #1;
   endtask
   always_ff @(posedge i_clk) o_seen <= i_out_line;
endmodule
`default_nettype wire

/* File: dv/tio_port_sva.sv */
// Purpose: port checks for tio_port
// Assumes: one clock, synchronous active-low reset
// Notes:   pin path takes three edges to reach the mode flag
`default_nettype none
module tio_port_sva (
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   input  wire logic       i_latch_n,
   input  wire logic       i_usb_link,
   input  wire logic       i_rd,
   input  wire logic       i_wr,
   input  wire logic [7:0] i_wdata,
   input  wire logic [7:0] o_rdata,
   input  wire logic       o_rvalid,
   input  wire logic [7:0] o_out_line,
   input  wire logic       o_latched,
   input  wire logic       o_avail
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   chk_wr_out:
      assert property (i_wr && !i_usb_link |=> o_out_line == $past(i_wdata))
      else $error("write lost");
   chk_out_hold:
      assert property (!i_wr || i_usb_link |=> $stable(o_out_line))
      else $error("outputs moved");
   chk_rd_valid:
      assert property (i_rd |=> o_rvalid) else $error("no read answer");
   chk_rv_pulse:
      assert property (!i_rd |=> !o_rvalid) else $error("stray answer");
   chk_usb_rdata:
      assert property (i_rd && i_usb_link |=> o_rdata == 8'h00)
      else $error("usb read data");
   chk_usb_avail:
      assert property (i_usb_link |=> !o_avail) else $error("usb avail");
   chk_latch_on:
      assert property ((!i_latch_n) [*4] |-> o_latched)
      else $error("latch flag late");
   chk_reset_low:
      assert property ($past(!i_resetn) |-> o_out_line == 8'h00)
      else $error("outputs not low");
endmodule
bind tio_port tio_port_sva tio_port_sva_inst (.i_clk, .i_resetn,
   .i_latch_n, .i_usb_link, .i_rd, .i_wr, .i_wdata, .o_rdata,
   .o_rvalid, .o_out_line, .o_latched, .o_avail);
`default_nettype wire

/* File: hw/tio_pkg.sv */
// Purpose: constants shared by the ttl input/output port
// Assumes: one 200 MHz clock, synchronous active-low reset
// Notes:   widths fixed, no software-visible registers
`default_nettype none
package tio_pkg;
   // ---------------------------------------------------------------
   // widths and reset values
   // ---------------------------------------------------------------
   localparam int             LINE_COUNT   = 8;
   localparam logic [7:0]     OUT_RESET    = 8'h00;
   localparam logic [7:0]     IN_RESET     = 8'hff;
   localparam logic           CTRL_RESET   = 1'b1;
   localparam logic           MODE_RESET   = 1'b0;
   localparam int             SYNC_STAGES  = 2;
   localparam logic [7:0]     READ_BLOCKED = 8'h00;
endpackage
`default_nettype wire

/* File: hw/tio_port.sv */
// Purpose: eight ttl inputs with live/latched read, eight held outputs
// Assumes: pins pulled up outside the die; software bus is plain strobes
// Notes:   all outputs registered; port masked on the usb 2.0 link
//
// Functional notes
// - inputs read as weighted binary byte
// - low input line reads as zero
// - unconnected input line reads as one
// - control high gives live input reads
// - control falling captures; hold while low
// - eight output lines, each set individually
// - output bit n drives line n+1
// - outputs hold until next write
// - port unavailable over usb 2.0 link
`default_nettype none
module tio_port (
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   input  wire logic [7:0] i_in_line,
   input  wire logic       i_latch_n,
   input  wire logic       i_usb_link,
   input  wire logic       i_rd,
   input  wire logic       i_wr,
   input  wire logic [7:0] i_wdata,
   output var  logic [7:0] o_rdata,
   output var  logic       o_rvalid,
   output var  logic [7:0] o_out_line,
   output var  logic       o_latched,
   output var  logic       o_avail
);
   // ---------------------------------------------------------------
   // types and state
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      TIO_LIVE = 2'b01,
      TIO_HELD = 2'b10
   } tio_mode_type;

   typedef struct packed {
      tio_mode_type mode;
      logic [7:0]   held;
      logic [7:0]   rdata;
      logic         rvalid;
      logic [7:0]   out_line;
      logic         avail;
   } tio_state_type;

   tio_state_type state;
   tio_state_type next_state;
   logic [8:0]    pins;
   logic [7:0]    live;
   logic          ctrl;

   // ---------------------------------------------------------------
   // pin synchroniser
   // ---------------------------------------------------------------
   tio_sync u_sync (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_async  ({i_latch_n, i_in_line}),
      .o_sync   (pins)
   );

   // bit order
   // line n lands on bit n-1, weight 2^(n-1)
   assign live = pins[7:0];
   assign ctrl = pins[8];

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_state        = state;
      next_state.rvalid = 1'b0;
      // usb masking
      // usb level sampled each cycle; not a pin, so no sync
      next_state.avail  = !i_usb_link;

      case (state.mode)
         TIO_LIVE: begin
            // capture on fall
            // captures the value seen in the same cycle as the edge
            if (!ctrl) begin
               next_state.mode = TIO_HELD;
               next_state.held = live;
            end
         end
         TIO_HELD: begin
            if (ctrl) begin
               next_state.mode = TIO_LIVE;
            end
         end
         default: begin
            next_state.mode = TIO_LIVE;
         end
      endcase

      if (i_rd) begin
         next_state.rvalid = 1'b1;
         if (i_usb_link) begin
            next_state.rdata = tio_pkg::READ_BLOCKED;
         end else if (state.mode == TIO_HELD) begin
            next_state.rdata = state.held;
         end else begin
            next_state.rdata = live;
         end
      end

      if (i_wr && !i_usb_link) begin
         next_state.out_line = i_wdata;
      end

      if (!i_resetn) begin
         next_state.mode     = TIO_LIVE;
         next_state.held     = tio_pkg::IN_RESET;
         next_state.rdata    = tio_pkg::READ_BLOCKED;
         next_state.rvalid   = 1'b0;
         next_state.out_line = tio_pkg::OUT_RESET;
         next_state.avail    = tio_pkg::MODE_RESET;
      end
   end

   always_ff @(posedge i_clk) begin
      state <= next_state;
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign o_rdata    = state.rdata;
   assign o_rvalid   = state.rvalid;
   assign o_out_line = state.out_line;
   assign o_latched  = state.mode[1];
   assign o_avail    = state.avail;
endmodule
`default_nettype wire

/* File: hw/tio_sync.sv */
// Purpose: two-flop synchroniser for the pin inputs
// Assumes: pins asynchronous to i_clk
// Notes:   first stage feeds only the second stage
`default_nettype none
module tio_sync (
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   input  wire logic [8:0] i_async,
   output var  logic [8:0] o_sync
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [8:0] stage1;
      logic [8:0] stage2;
   } tio_sync_state_type;

   tio_sync_state_type state;
   tio_sync_state_type next_state;

   always_comb begin
      next_state        = state;
      next_state.stage1 = i_async;
      next_state.stage2 = state.stage1;
      // idle pins read high, as a pulled-up line would
      if (!i_resetn) begin
         next_state.stage1 = {tio_pkg::CTRL_RESET, tio_pkg::IN_RESET};
         next_state.stage2 = {tio_pkg::CTRL_RESET, tio_pkg::IN_RESET};
      end
   end

   always_ff @(posedge i_clk) begin
      state <= next_state;
   end

   assign o_sync = state.stage2;
endmodule
`default_nettype wire
